// ### core/pca_mode_regs.vh
// register map, field positions, reset values and divider counts of the counter mode block
// assumes register indices are word indices: byte address = 4 * index
`ifndef PCA_MODE_REGS_VH
`define PCA_MODE_REGS_VH

// ****************************************
// register indices
// ****************************************
`define COUNTER_MODE_IDX   10'h0d9
`define RUN_CONTROL_IDX    10'h0e0
`define COUNTER_VALUE_IDX  10'h0e1
`define IRQ_STATUS_IDX     10'h0e2
`define IRQ_CLEAR_IDX      10'h0e3
`define IRQ_ENABLE_IDX     10'h0e4

// ****************************************
// counter_mode fields
// ****************************************
`define IDLE_SUSPEND_POS   7
`define WDT_ENABLE_POS     6
`define WDT_LOCK_POS       5
`define UNUSED_POS         4
`define TB_SELECT_HI       3
`define TB_SELECT_LO       1
`define OVF_IRQ_EN_POS     0

// ****************************************
// status, clear, enable and run control fields
// ****************************************
`define STAT_OVERFLOW_POS  0
`define STAT_WDT_POS       1
`define RUN_POS            0

// ****************************************
// reset values
// ****************************************
`define COUNTER_MODE_RST   8'h40
`define IRQ_ENABLE_RST     2'h0
`define RUN_CONTROL_RST    1'h0

// ****************************************
// timebase codes
// ****************************************
`define TB_SYS_DIV12       3'h0
`define TB_SYS_DIV4        3'h1
`define TB_TIMER0_OVF      3'h2
`define TB_EXT_FALL        3'h3
`define TB_SYS_CLK         3'h4
`define TB_EXT_DIV8        3'h5

// ****************************************
// divider counts
// ****************************************
`define DIV_SLOW_COUNT     4'hc
`define DIV_FAST_COUNT     4'h4
`define EXT_DIV_COUNT      4'h8

// ****************************************
// bus responses
// ****************************************
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ### core/sync2.v
// two flip-flop synchroniser for a level arriving from outside the clock domain
// assumes a synchronous active-low reset on the same clock
`timescale 1ns/1ns
`default_nettype none

module sync2 (
   // clock and reset
   input  wire aclk,
   input  wire aresetn,
   // level in and out
   input  wire async_level,
   output reg  sync_level
);

   reg stage1;

   always @(posedge aclk) begin
      if (!aresetn) begin
         stage1     <= 1'b0;
         sync_level <= 1'b0;
      end else begin
         stage1     <= async_level;
         sync_level <= stage1;
      end
   end

endmodule

`default_nettype wire

// ### core/timebase_select_unit.v
// timebase source selection: one-cycle tick per counter increment
// assumes external levels are already synchronised to aclk
`timescale 1ns/1ns
`default_nettype none
`include "pca_mode_regs.vh"

module timebase_select_unit #(
   parameter [3:0] DIV_SLOW = `DIV_SLOW_COUNT,
   parameter [3:0] DIV_FAST = `DIV_FAST_COUNT,
   parameter [3:0] EXT_DIV  = `EXT_DIV_COUNT
) (
   // clock and reset
   input  wire       aclk,
   input  wire       aresetn,
   // source choice and events
   input  wire [2:0] select,
   input  wire       timer0_overflow,
   input  wire       ext_count_level,
   input  wire       ext_clock_level,
   // increment pulse
   output reg        tick
);

   reg  [3:0] slow_count;
   reg  [3:0] fast_count;
   reg  [3:0] ext_count;
   reg        count_prev;
   reg        clock_prev;
   reg        next_tick;
   wire       slow_wrap  = (slow_count == DIV_SLOW - 4'h1);
   wire       fast_wrap  = (fast_count == DIV_FAST - 4'h1);
   wire       count_fall = count_prev & ~ext_count_level;
   wire       clock_rise = ~clock_prev & ext_clock_level;
   wire       ext_wrap   = clock_rise & (ext_count == EXT_DIV - 4'h1);

   // ****************************************
   // prescalers and edge detection
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         slow_count <= 4'h0;
         fast_count <= 4'h0;
         ext_count  <= 4'h0;
         count_prev <= 1'b0;
         // starts high, but sync2 resets low, so a clock pin idling high still gives one false rise just after reset
         clock_prev <= 1'b1;
         tick       <= 1'b0;
      end else begin
         slow_count <= slow_wrap ? 4'h0 : slow_count + 4'h1;
         fast_count <= fast_wrap ? 4'h0 : fast_count + 4'h1;
         if (clock_rise) begin
            ext_count <= ext_wrap ? 4'h0 : ext_count + 4'h1;
         end
         count_prev <= ext_count_level;
         clock_prev <= ext_clock_level;
         tick       <= next_tick;
      end
   end

   // ****************************************
   // source multiplexer
   // ****************************************
   always @* begin
      case (select)
         `TB_SYS_DIV12:  next_tick = slow_wrap;
         `TB_SYS_DIV4:   next_tick = fast_wrap;
         `TB_TIMER0_OVF: next_tick = timer0_overflow;
         `TB_EXT_FALL:   next_tick = count_fall;
         `TB_SYS_CLK:    next_tick = 1'b1;
         `TB_EXT_DIV8:   next_tick = ext_wrap;
         default:        next_tick = 1'b0;
      endcase
   end

endmodule

`default_nettype wire

// ### core/pca_mode_control.v
// counter mode control: mode register, 16-bit counter, watchdog enable and interrupt
// assumes an AXI4-Lite master on aclk and one outstanding read and write at most
`timescale 1ns/1ns
`default_nettype none
`include "pca_mode_regs.vh"

module pca_mode_control #(
   parameter ADDR_WIDTH = 12
) (
   // clock and reset
   input  wire                  aclk,
   input  wire                  aresetn,
   // write address channel
   input  wire [ADDR_WIDTH-1:0] awaddr,
   input  wire [2:0]            awprot,
   input  wire                  awvalid,
   output reg                   awready,
   // write data channel
   input  wire [31:0]           wdata,
   input  wire [3:0]            wstrb,
   input  wire                  wvalid,
   output reg                   wready,
   // write response channel
   output reg  [1:0]            bresp,
   output reg                   bvalid,
   input  wire                  bready,
   // read address channel
   input  wire [ADDR_WIDTH-1:0] araddr,
   input  wire [2:0]            arprot,
   input  wire                  arvalid,
   output reg                   arready,
   // read data channel
   output reg  [31:0]           rdata,
   output reg  [1:0]            rresp,
   output reg                   rvalid,
   input  wire                  rready,
   // system side
   input  wire                  cpu_idle,
   input  wire                  timer0_overflow,
   input  wire                  module2_match,
   // pins
   input  wire                  external_count_input,
   input  wire                  external_clock,
   // array side
   output reg  [15:0]           counter_value,
   output reg                   counter_overflow_flag,
   output reg                   watchdog_enable_bit,
   output reg                   watchdog_reset,
   output reg                   irq
);

   // ****************************************
   // helpers
   // ****************************************
   function [9:0] reg_index;
      input [ADDR_WIDTH-1:0] addr;
      begin
         reg_index = addr[11:2];
      end
   endfunction

   function mapped;
      input [9:0] idx;
      begin
         mapped = (idx == `COUNTER_MODE_IDX) || (idx == `RUN_CONTROL_IDX) ||
                  (idx == `COUNTER_VALUE_IDX) || (idx == `IRQ_STATUS_IDX) ||
                  (idx == `IRQ_CLEAR_IDX) || (idx == `IRQ_ENABLE_IDX);
      end
   endfunction

   // ****************************************
   // reset image
   // ****************************************
   // mode register reset value, taken apart field by field below
   localparam [7:0] MODE_RESET = `COUNTER_MODE_RST;

   // ****************************************
   // state
   // ****************************************
   reg                  idle_suspend;
   reg                  watchdog_lock_bit;
   reg [2:0]            timebase_select;
   reg                  overflow_irq_enable;
   reg                  run;
   reg                  watchdog_expired;
   reg [1:0]            irq_enable;
   reg                  aw_full;
   reg                  w_full;
   reg [ADDR_WIDTH-1:0] aw_addr;
   reg [31:0]           w_data;
   reg [3:0]            w_strb;
   reg [31:0]           next_rdata;
   reg [1:0]            next_rresp;

   wire       count_sync;
   wire       clock_sync;
   wire       tick;
   wire [9:0] w_idx      = reg_index(aw_addr);
   wire [9:0] r_idx      = reg_index(araddr);
   wire       do_write   = aw_full & w_full & ~bvalid;
   // an unaligned write is answered with an error and must change nothing
   wire       lane0      = do_write & w_strb[0] & (aw_addr[1:0] == 2'h0);
   wire       mode_wr    = lane0 & (w_idx == `COUNTER_MODE_IDX);
   wire       run_wr     = lane0 & (w_idx == `RUN_CONTROL_IDX);
   wire       clear_wr   = lane0 & (w_idx == `IRQ_CLEAR_IDX);
   wire       enable_wr  = lane0 & (w_idx == `IRQ_ENABLE_IDX);
   wire [7:0] mode_read  = {idle_suspend, watchdog_enable_bit, watchdog_lock_bit, 1'b0,
                            timebase_select, overflow_irq_enable};
   wire       advance    = tick & run & ~(idle_suspend & cpu_idle);
   wire       wrap       = advance & (counter_value == 16'hffff);

   // ****************************************
   // pin synchronisers and timebase
   // ****************************************
   sync2 count_sync_unit (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .async_level (external_count_input),
      .sync_level  (count_sync)
   );

   sync2 clock_sync_unit (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .async_level (external_clock),
      .sync_level  (clock_sync)
   );

   timebase_select_unit timebase (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .select          (timebase_select),
      .timer0_overflow (timer0_overflow),
      .ext_count_level (count_sync),
      .ext_clock_level (clock_sync),
      .tick            (tick)
   );

   // ****************************************
   // write channels
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         aw_full <= 1'b0;
         w_full  <= 1'b0;
         aw_addr <= {ADDR_WIDTH{1'b0}};
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= `RESP_OKAY;
      end else begin
         if (awvalid & awready) begin
            aw_addr <= awaddr;
            aw_full <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid & wready) begin
            w_data <= wdata;
            w_strb <= wstrb;
            w_full <= 1'b1;
            wready <= 1'b0;
         end
         if (bvalid & bready) begin
            bvalid <= 1'b0;
         end
         // lands only once both halves are held and the last answer has drained
         if (do_write) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b1;
            bresp   <= (mapped(w_idx) && aw_addr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // ****************************************
   // mode, run and enable registers
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         idle_suspend        <= MODE_RESET[`IDLE_SUSPEND_POS];
         watchdog_enable_bit <= MODE_RESET[`WDT_ENABLE_POS];
         watchdog_lock_bit   <= MODE_RESET[`WDT_LOCK_POS];
         timebase_select     <= MODE_RESET[`TB_SELECT_HI:`TB_SELECT_LO];
         overflow_irq_enable <= MODE_RESET[`OVF_IRQ_EN_POS];
         run                 <= `RUN_CONTROL_RST;
         irq_enable          <= `IRQ_ENABLE_RST;
      end else begin
         if (mode_wr) begin
            if (!watchdog_enable_bit) begin
               idle_suspend        <= w_data[`IDLE_SUSPEND_POS];
               timebase_select     <= w_data[`TB_SELECT_HI:`TB_SELECT_LO];
               overflow_irq_enable <= w_data[`OVF_IRQ_EN_POS];
            end
            // lock only sets; enable cannot be cleared while locked
            watchdog_lock_bit   <= watchdog_lock_bit | w_data[`WDT_LOCK_POS];
            watchdog_enable_bit <= w_data[`WDT_ENABLE_POS] |
                                   (watchdog_lock_bit & watchdog_enable_bit);
         end
         if (run_wr) begin
            run <= w_data[`RUN_POS];
         end
         if (enable_wr) begin
            irq_enable <= w_data[1:0];
         end
      end
   end

   // ****************************************
   // counter, flags and interrupt
   // ****************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         counter_value         <= 16'h0000;
         counter_overflow_flag <= 1'b0;
         watchdog_expired      <= 1'b0;
         watchdog_reset        <= 1'b0;
         irq                   <= 1'b0;
      end else begin
         if (advance) begin
            counter_value <= counter_value + 16'h0001;
         end
         // a set in the same cycle as a clear wins
         if (clear_wr & w_data[`STAT_OVERFLOW_POS]) begin
            counter_overflow_flag <= 1'b0;
         end
         if (wrap) begin
            counter_overflow_flag <= 1'b1;
         end
         if (clear_wr & w_data[`STAT_WDT_POS]) begin
            watchdog_expired <= 1'b0;
         end
         if (watchdog_enable_bit & module2_match) begin
            watchdog_expired <= 1'b1;
         end
         watchdog_reset <= watchdog_enable_bit & module2_match;
         irq <= (counter_overflow_flag & overflow_irq_enable & irq_enable[`STAT_OVERFLOW_POS]) |
                (watchdog_expired & irq_enable[`STAT_WDT_POS]);
      end
   end

   // ****************************************
   // read channels
   // ****************************************
   always @* begin
      next_rdata = 32'h0000_0000;
      next_rresp = `RESP_OKAY;
      if (araddr[1:0] != 2'h0) begin
         next_rresp = `RESP_SLVERR;
      end else begin
         case (r_idx)
            `COUNTER_MODE_IDX:  next_rdata = {24'h00_0000, mode_read};
            `RUN_CONTROL_IDX:   next_rdata = {31'h0000_0000, run};
            `COUNTER_VALUE_IDX: next_rdata = {16'h0000, counter_value};
            `IRQ_STATUS_IDX:    next_rdata = {30'h0000_0000, watchdog_expired,
                                              counter_overflow_flag};
            `IRQ_CLEAR_IDX:     next_rdata = 32'h0000_0000;
            `IRQ_ENABLE_IDX:    next_rdata = {30'h0000_0000, irq_enable};
            default:            next_rresp = `RESP_SLVERR;
         endcase
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `RESP_OKAY;
      end else begin
         // read data are a snapshot taken at the address handshake
         if (arvalid & arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
         end
         if (rvalid & rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ### testbench/pca_mode_monitor.sv
// assertions on the ports of the counter mode block
// assumes it is bound to pca_mode_control, one clock, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none

module pca_mode_monitor (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // register bus
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   // array side
   input wire logic        module2_match,
   input wire logic [15:0] counter_value,
   input wire logic        counter_overflow_flag,
   input wire logic        watchdog_enable_bit,
   input wire logic        watchdog_reset
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_wr_answer;
      !awready && !wready ##1 bvalid;
   endsequence

   property p_wr_lat;
      s_wr_taken |=> s_wr_answer;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");

   property p_rd_lat;
      arvalid && arready |=> rvalid && !arready;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");

   property p_wdt_pulse;
      module2_match && watchdog_enable_bit |=> watchdog_reset;
   endproperty
   a_wdt_pulse: assert property (p_wdt_pulse) else $error("no watchdog pulse");

   property p_wdt_cause;
      watchdog_reset |-> $past(module2_match) && $past(watchdog_enable_bit);
   endproperty
   a_wdt_cause: assert property (p_wdt_cause) else $error("stray watchdog pulse");

   property p_ovf_set;
      counter_value == 16'h0000 && $past(counter_value) == 16'hffff |-> counter_overflow_flag;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("wrap without flag");

   property p_flag_sticky;
      counter_overflow_flag && awready |=> counter_overflow_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag fell without write");

   property p_cnt_step;
      $changed(counter_value) |-> counter_value == $past(counter_value) + 16'h0001;
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("counter jumped");

   property p_watchdog_enable_bit_fall;
      $fell(watchdog_enable_bit) |-> $rose(bvalid);
   endproperty
   a_watchdog_enable_bit_fall: assert property (p_watchdog_enable_bit_fall) else $error("enable fell unasked");
endmodule

bind pca_mode_control pca_mode_monitor mon (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
   .arready(arready), .rvalid(rvalid), .module2_match(module2_match),
   .counter_value(counter_value), .counter_overflow_flag(counter_overflow_flag),
   .watchdog_enable_bit(watchdog_enable_bit), .watchdog_reset(watchdog_reset)
);

`default_nettype wire

// ### testbench/pca_mode_control_tb_top.sv
// self-checking bench for the counter mode block
// assumes the register map header on the include path and a 25 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "pca_mode_regs.vh"

module pca_mode_control_tb_top;
   localparam [11:0] MODE_A = {`COUNTER_MODE_IDX, 2'b00};
   localparam [11:0] RUN_A  = {`RUN_CONTROL_IDX, 2'b00};
   localparam [11:0] STAT_A = {`IRQ_STATUS_IDX, 2'b00};
   localparam [11:0] CLR_A  = {`IRQ_CLEAR_IDX, 2'b00};
   localparam [11:0] EN_A   = {`IRQ_ENABLE_IDX, 2'b00};
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        arvalid = 1'b0;
   logic        cpu_idle = 1'b0;
   logic        timer0_overflow = 1'b0;
   logic        module2_match = 1'b0;
   logic        ext_count = 1'b1;
   logic        ext_clock = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] counter_value, base;
   logic        counter_overflow_flag, watchdog_enable_bit, watchdog_reset, irq;
   int          failures = 0;
   int          checked = 0;
   logic [7:0]  modes [5] = '{8'h00, 8'h02, 8'h08, 8'h0c, 8'h0e};
   logic [15:0] steps [5] = '{16'h0004, 16'h000c, 16'h0030, 16'h0000, 16'h0000};

   always #20 aclk = ~aclk;

   pca_mode_control uut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arprot(3'h0),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(1'b1), .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
      .module2_match(module2_match), .external_count_input(ext_count),
      .external_clock(ext_clock), .counter_value(counter_value),
      .counter_overflow_flag(counter_overflow_flag), .watchdog_enable_bit(watchdog_enable_bit),
      .watchdog_reset(watchdog_reset), .irq(irq)
   );

   // ****************************************
   // bus and check tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && n < 100);
      if (n >= 100) failures++;
      chk(bresp, `RESP_OKAY);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && n < 100);
      if (n >= 100) failures++;
      chk(rdata, exp);
      chk(rresp, er);
   endtask

   task automatic settle_mark(input logic [7:0] m);
      wr(MODE_A, {24'h00_0000, m});
      repeat (4) @(posedge aclk);
      base = counter_value;
   endtask

   task automatic since(input logic [15:0] exp);
      chk({16'h0000, counter_value - base}, {16'h0000, exp});
   endtask

   task automatic pulse_match(input logic exp);
      module2_match <= 1'b1;
      @(posedge aclk);
      module2_match <= 1'b0;
      @(posedge aclk);
      chk({31'h0, watchdog_reset}, {31'h0, exp});
      repeat (2) @(posedge aclk);
   endtask

   task automatic final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial begin
      int n;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(MODE_A, 32'h0000_0040, `RESP_OKAY);
      wr(MODE_A, 32'h0000_005f);
      rd(MODE_A, 32'h0000_0040, `RESP_OKAY);
      pulse_match(1'b1);
      rd(STAT_A, 32'h0000_0002, `RESP_OKAY);
      wr(CLR_A, 32'h0000_0002);
      wr(MODE_A, 32'h0000_0000);
      chk(watchdog_enable_bit, 1'b0);
      pulse_match(1'b0);
      rd(STAT_A, 32'h0000_0000, `RESP_OKAY);
      wr(MODE_A, 32'h0000_001f);
      rd(MODE_A, 32'h0000_000f, `RESP_OKAY);
      wr(RUN_A, 32'h0000_0001);
      for (int i = 0; i < 5; i++) begin
         settle_mark(modes[i]);
         repeat (48) @(posedge aclk);
         since(steps[i]);
      end
      settle_mark(8'h04);
      repeat (3) begin
         timer0_overflow <= 1'b1;
         @(posedge aclk);
         timer0_overflow <= 1'b0;
         repeat (3) @(posedge aclk);
      end
      since(16'h0003);
      settle_mark(8'h06);
      repeat (5) begin
         ext_count <= 1'b0;
         repeat (4) @(posedge aclk);
         ext_count <= 1'b1;
         repeat (4) @(posedge aclk);
      end
      since(16'h0005);
      settle_mark(8'h0a);
      repeat (16) begin
         ext_clock <= 1'b1;
         repeat (2) @(posedge aclk);
         ext_clock <= 1'b0;
         repeat (2) @(posedge aclk);
      end
      repeat (8) @(posedge aclk);
      since(16'h0002);
      cpu_idle <= 1'b1;
      settle_mark(8'h88);
      repeat (48) @(posedge aclk);
      since(16'h0000);
      settle_mark(8'h08);
      repeat (48) @(posedge aclk);
      since(16'h0030);
      cpu_idle <= 1'b0;
      wr(EN_A, 32'h0000_0001);
      n = 0;
      while (counter_value !== 16'hffff && n < 70000) begin
         @(posedge aclk);
         n++;
      end
      if (n >= 70000) failures++;
      repeat (2) @(posedge aclk);
      wr(RUN_A, 32'h0000_0000);
      chk(counter_overflow_flag, 1'b1);
      chk(irq, 1'b0);
      rd(STAT_A, 32'h0000_0001, `RESP_OKAY);
      wr(MODE_A, 32'h0000_0009);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b1);
      wr(CLR_A, 32'h0000_0001);
      repeat (2) @(posedge aclk);
      chk(counter_overflow_flag, 1'b0);
      chk(irq, 1'b0);
      wr(MODE_A, 32'h0000_0040);
      wr(MODE_A, 32'h0000_0060);
      wr(MODE_A, 32'h0000_0000);
      rd(MODE_A, 32'h0000_0060, `RESP_OKAY);
      chk(watchdog_enable_bit, 1'b1);
      rd(12'h3fc, 32'h0000_0000, `RESP_SLVERR);
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(MODE_A, 32'h0000_0040, `RESP_OKAY);
      wr(MODE_A, 32'h0000_0000);
      rd(MODE_A, 32'h0000_0000, `RESP_OKAY);
      final_report;
   end

   // hang guard, about the span of the overflow wait plus margin
   initial begin
      repeat (90000) @(posedge aclk);
      failures++;
      final_report;
   end
endmodule

`default_nettype wire
